// ### core/dtfm_params.svh
`ifndef DTFM_PARAMS_SVH
`define DTFM_PARAMS_SVH
// input function codes
`define DTFM_IN_MULTISTEP0    6'h00
`define DTFM_IN_RAMP0         6'h04
`define DTFM_IN_RAMP1         6'h05
`define DTFM_IN_TORQUE2       6'h0E
`define DTFM_IN_LINK_EN       6'h18
`define DTFM_IN_GP_READ       6'h19
`define DTFM_IN_PICKUP        6'h1A
`define DTFM_IN_STOP_CUR      6'h1B
`define DTFM_IN_STOP_FOURTH   6'h1C
// output codes
`define DTFM_OUT_RUNNING      6'h00
`define DTFM_OUT_UNASSIGNED   6'h1E
`define DTFM_OUT_LAST         6'h22
// terminal counts and field widths
`define DTFM_NUM_IN           9
`define DTFM_NUM_OUT          5
`define DTFM_CODE_W           6
`define DTFM_SIG_W            35
// register offsets
`define DTFM_REG_IN_CODE0     8'h00
`define DTFM_REG_OUT_CODE0    8'h10
`define DTFM_REG_STATUS       8'h20
`define DTFM_REG_IRQ_STAT     8'h24
`define DTFM_REG_IRQ_MASK     8'h28
`define DTFM_REG_INPUTS       8'h2C
`define DTFM_REG_OUTPUTS      8'h30
// interrupt bit positions
`define DTFM_IRQ_FSTOP        0
`define DTFM_IRQ_RAMP_CHG     1
`define DTFM_IRQ_W            2
`endif

// ### core/dtfm_pkg.sv
package dtfm_pkg;
  // functions decoded from the input terminals
  typedef struct packed {
    logic       link_command_enable;
    logic       pickup_start_enable;
    logic       torque_limit_two;
    logic [1:0] ramp_select;
    logic       forced_stop_current_ramp;
    logic       forced_stop_fourth_ramp;
    logic [8:0] general_readable_input;
  } dtfm_in_fn_t;

  // drive control results
  typedef struct packed {
    logic       link_accept;
    logic       pickup_enable;
    logic       torque_set_two;
    logic [1:0] ramp_pair;
    logic       forced_stop;
    logic       use_fourth_decel;
    logic       forced_stop_alarm;
  } dtfm_ctrl_t;

  typedef enum logic [2:0] {
    DTFM_IDLE     = 3'b001,
    DTFM_RUN      = 3'b010,
    DTFM_STOPPING = 3'b100
  } dtfm_state_t;
endpackage

// ### core/dtfm_in_sync.sv
`timescale 1ns/1ps
`include "dtfm_params.svh"
// three-stage synchroniser; change accepted once stages two and three agree
module dtfm_in_sync #(
  parameter int WIDTH = 9
) (
  // clocking
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, lvl_r;
  logic [WIDTH-1:0] lvl_nxt;

  always_comb begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      lvl_r <= '0;
    end else if (clk_en) begin
      s1_r  <= pin_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;
endmodule // dtfm_in_sync

// ### core/dtfm_out_sel.sv
`timescale 1ns/1ps
`include "dtfm_params.svh"
// one output terminal: picks the status signal named by its code
module dtfm_out_sel (
  // selection
  input  wire logic [`DTFM_CODE_W-1:0] code,
  input  wire logic [`DTFM_SIG_W-1:0]  sig_vec,
  // result
  output logic                         sel_out
);
  always_comb begin
    if (code == `DTFM_OUT_UNASSIGNED || code > `DTFM_OUT_LAST) begin
      sel_out = 1'b0;
    end else begin
      sel_out = sig_vec[code];
    end
  end
endmodule // dtfm_out_sel

// ### core/dtfm_mux.sv
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "dtfm_params.svh"
module dtfm_mux #(
  parameter int NUM_IN  = `DTFM_NUM_IN,
  parameter int NUM_OUT = `DTFM_NUM_OUT
) (
  // clocking
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 clk_en,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // terminals
  input  wire logic [NUM_IN-1:0]    term_in,
  output logic      [NUM_OUT-1:0]   term_out,
  // drive status
  input  wire logic                 freq_output_active,
  input  wire logic                 dc_brake_active,
  input  wire logic                 motor_stopped,
  input  wire logic [`DTFM_SIG_W-1:0] status_sig,
  // drive control
  output dtfm_pkg::dtfm_ctrl_t      ctrl,
  output logic                      irq
);
  logic [NUM_IN-1:0]             in_lvl;
  logic [`DTFM_CODE_W-1:0]       in_code_r  [NUM_IN];
  logic [`DTFM_CODE_W-1:0]       in_code_nxt[NUM_IN];
  logic [`DTFM_CODE_W-1:0]       out_code_r  [NUM_OUT];
  logic [`DTFM_CODE_W-1:0]       out_code_nxt[NUM_OUT];
  logic [`DTFM_IRQ_W-1:0]        irq_stat_r, irq_stat_nxt;
  logic [`DTFM_IRQ_W-1:0]        irq_mask_r, irq_mask_nxt;
  logic [31:0]                   rdata_r, rdata_nxt;
  logic [NUM_OUT-1:0]            out_r, out_nxt;
  logic [NUM_OUT-1:0]            out_sel;
  logic [`DTFM_SIG_W-1:0]        sig_vec;
  logic                          irq_r, irq_nxt;
  dtfm_pkg::dtfm_in_fn_t         fn;
  dtfm_pkg::dtfm_ctrl_t          ctrl_r, ctrl_nxt;
  dtfm_pkg::dtfm_state_t         state_r, state_nxt;
  logic                          stop_ev;
  logic                          ramp_ev;
  logic [NUM_IN-1:0]             in_code_we;
  logic [NUM_OUT-1:0]            out_code_we;

  dtfm_in_sync #(.WIDTH(NUM_IN)) u_sync (
    .clk       (clk),
    .reset     (reset),
    .clk_en    (clk_en),
    .pin_in    (term_in),
    .level_out (in_lvl)
  );

  // input function decode; functions with no assigned terminal read off
  always_comb begin
    fn = '0;
    fn.forced_stop_current_ramp = 1'b1;
    fn.forced_stop_fourth_ramp  = 1'b1;
    for (int i = 0; i < NUM_IN; i++) begin
      case (in_code_r[i])
        `DTFM_IN_LINK_EN:    fn.link_command_enable = in_lvl[i];
        `DTFM_IN_GP_READ:    fn.general_readable_input[i] = in_lvl[i];
        `DTFM_IN_PICKUP:     fn.pickup_start_enable = in_lvl[i];
        `DTFM_IN_TORQUE2:    fn.torque_limit_two = in_lvl[i];
        `DTFM_IN_RAMP0:      fn.ramp_select[0] = in_lvl[i];
        `DTFM_IN_RAMP1:      fn.ramp_select[1] = in_lvl[i];
        `DTFM_IN_STOP_CUR: begin
          fn.forced_stop_current_ramp = in_lvl[i];
        end
        `DTFM_IN_STOP_FOURTH: begin
          fn.forced_stop_fourth_ramp = in_lvl[i];
        end
        default: ;
      endcase
    end
  end

  // forced-stop sequencer
  always_comb begin
    state_nxt = state_r;
    stop_ev   = 1'b0;
    ctrl_nxt  = ctrl_r;
    ctrl_nxt.link_accept    = fn.link_command_enable;
    ctrl_nxt.pickup_enable  = fn.pickup_start_enable;
    ctrl_nxt.torque_set_two = fn.torque_limit_two;
    ctrl_nxt.ramp_pair      = fn.ramp_select;
    case (state_r)
      dtfm_pkg::DTFM_IDLE: begin
        ctrl_nxt.forced_stop = 1'b0;
        if (freq_output_active) begin
          state_nxt = dtfm_pkg::DTFM_RUN;
        end
      end
      dtfm_pkg::DTFM_RUN: begin
        if (!fn.forced_stop_current_ramp ||
            !fn.forced_stop_fourth_ramp) begin
          state_nxt                 = dtfm_pkg::DTFM_STOPPING;
          stop_ev                   = 1'b1;
          ctrl_nxt.forced_stop      = 1'b1;
          ctrl_nxt.link_accept      = 1'b0;
          ctrl_nxt.forced_stop_alarm = 1'b1;
          ctrl_nxt.use_fourth_decel = !fn.forced_stop_fourth_ramp;
        end else if (!freq_output_active) begin
          state_nxt = dtfm_pkg::DTFM_IDLE;
        end
      end
      dtfm_pkg::DTFM_STOPPING: begin
        ctrl_nxt.link_accept = 1'b0;
        if (motor_stopped) begin
          state_nxt            = dtfm_pkg::DTFM_IDLE;
          ctrl_nxt.forced_stop = 1'b0;
        end
      end
      default: state_nxt = dtfm_pkg::DTFM_IDLE;
    endcase
    if (state_r != dtfm_pkg::DTFM_STOPPING && !stop_ev) begin
      ctrl_nxt.use_fourth_decel = 1'b0;
    end
    // alarm holds until idle with both stop inputs released and no frequency output
    if (state_r == dtfm_pkg::DTFM_IDLE && fn.forced_stop_current_ramp &&
        fn.forced_stop_fourth_ramp && !freq_output_active) begin
      ctrl_nxt.forced_stop_alarm = 1'b0;
    end
  end

  assign ramp_ev = (ctrl_r.ramp_pair != fn.ramp_select);

  // status vector with the running signal built here
  always_comb begin
    sig_vec = status_sig;
    sig_vec[`DTFM_OUT_RUNNING] = freq_output_active &&
                                 !dc_brake_active;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      dtfm_out_sel u_sel (
        .code    (out_code_r[g]),
        .sig_vec (sig_vec),
        .sel_out (out_sel[g])
      );
    end
  endgenerate

  always_comb begin
    out_nxt = out_sel;
  end

  // one write enable per code register
  generate
    for (g = 0; g < NUM_IN; g++) begin : g_in_we
      assign in_code_we[g] = reg_wr &&
                             (reg_addr == `DTFM_REG_IN_CODE0 + 8'(g));
    end
    for (g = 0; g < NUM_OUT; g++) begin : g_out_we
      assign out_code_we[g] = reg_wr &&
                              (reg_addr == `DTFM_REG_OUT_CODE0 + 8'(g));
    end
  endgenerate

  // terminal function codes
  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      in_code_nxt[i] = in_code_r[i];
      if (in_code_we[i]) begin
        in_code_nxt[i] = reg_wdata[`DTFM_CODE_W-1:0];
      end
    end
    for (int j = 0; j < NUM_OUT; j++) begin
      out_code_nxt[j] = out_code_r[j];
      if (out_code_we[j]) begin
        out_code_nxt[j] = reg_wdata[`DTFM_CODE_W-1:0];
      end
    end
  end

  // inputs leave reset with the shipped assignment, terminal i code i
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_IN; i++) begin
        in_code_r[i] <= i[`DTFM_CODE_W-1:0];
      end
      for (int j = 0; j < NUM_OUT; j++) begin
        out_code_r[j] <= `DTFM_OUT_RUNNING;
      end
    end else if (clk_en) begin
      in_code_r  <= in_code_nxt;
      out_code_r <= out_code_nxt;
    end
  end

  // sticky events, cleared by writing ones; a same-cycle event wins
  always_comb begin
    irq_mask_nxt = irq_mask_r;
    if (reg_wr && reg_addr == `DTFM_REG_IRQ_MASK) begin
      irq_mask_nxt = reg_wdata[`DTFM_IRQ_W-1:0];
    end
    irq_stat_nxt = irq_stat_r;
    if (reg_wr && reg_addr == `DTFM_REG_IRQ_STAT) begin
      irq_stat_nxt = irq_stat_r & ~reg_wdata[`DTFM_IRQ_W-1:0];
    end
    if (stop_ev) begin
      irq_stat_nxt[`DTFM_IRQ_FSTOP] = 1'b1;
    end
    if (ramp_ev) begin
      irq_stat_nxt[`DTFM_IRQ_RAMP_CHG] = 1'b1;
    end
    // level output follows the masked status from the next edge
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq_r      <= 1'b0;
    end else if (clk_en) begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (reg_addr == `DTFM_REG_IN_CODE0 + 8'(i)) begin
          rdata_nxt = 32'(in_code_r[i]);
        end
      end
      for (int j = 0; j < NUM_OUT; j++) begin
        if (reg_addr == `DTFM_REG_OUT_CODE0 + 8'(j)) begin
          rdata_nxt = 32'(out_code_r[j]);
        end
      end
      // status word: sequencer state above the control bits
      case (reg_addr)
        `DTFM_REG_STATUS:   rdata_nxt = 32'({state_r, ctrl_r});
        `DTFM_REG_IRQ_STAT: rdata_nxt = 32'(irq_stat_r);
        `DTFM_REG_IRQ_MASK: rdata_nxt = 32'(irq_mask_r);
        `DTFM_REG_INPUTS:   rdata_nxt = 32'(fn.general_readable_input);
        `DTFM_REG_OUTPUTS:  rdata_nxt = 32'(out_r);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  // output terminals are driven only from these flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_r <= '0;
    end else if (clk_en) begin
      out_r <= out_nxt;
    end
  end

  // forced-stop sequencer state and drive controls
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r  <= '0;
      state_r <= dtfm_pkg::DTFM_IDLE;
    end else if (clk_en) begin
      ctrl_r  <= ctrl_nxt;
      state_r <= state_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign term_out  = out_r;
  assign ctrl      = ctrl_r;
  assign irq       = irq_r;
endmodule // dtfm_mux

// ### tb/dtfm_mux_chk.sv
`timescale 1ns/1ps
`include "dtfm_params.svh"
module dtfm_mux_chk #(
  parameter int NUM_IN  = 9,
  parameter int NUM_OUT = 5
) (
  // clocking
  input wire logic                      clk,
  input wire logic                      reset,
  input wire logic                      clk_en,
  // register port
  input wire logic [7:0]                reg_addr,
  input wire logic [31:0]               reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [31:0]               reg_rdata,
  // terminals
  input wire logic [NUM_IN-1:0]         term_in,
  input wire logic [NUM_OUT-1:0]        term_out,
  // drive status
  input wire logic                      freq_output_active,
  input wire logic                      dc_brake_active,
  input wire logic                      motor_stopped,
  input wire logic [`DTFM_SIG_W-1:0]    status_sig,
  // drive control
  input wire dtfm_pkg::dtfm_ctrl_t      ctrl,
  input wire logic                      irq
);
  logic [5:0]         code_q [NUM_OUT];
  logic [NUM_OUT-1:0] exp_q;
  logic [NUM_OUT-1:0] off_q;
  // shadow of the output codes and the levels they should produce
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int j = 0; j < NUM_OUT; j++) code_q[j] <= 6'h00;
      exp_q <= '0;
      off_q <= '0;
    end else if (clk_en) begin
      for (int j = 0; j < NUM_OUT; j++) begin
        if (code_q[j] == `DTFM_OUT_RUNNING)
          exp_q[j] <= freq_output_active & ~dc_brake_active;
        else if (code_q[j] == `DTFM_OUT_UNASSIGNED ||
                 code_q[j] > `DTFM_OUT_LAST)
          exp_q[j] <= 1'b0;
        else
          exp_q[j] <= status_sig[code_q[j]];
        off_q[j] <= code_q[j] == `DTFM_OUT_UNASSIGNED;
        if (reg_wr && reg_addr == `DTFM_REG_OUT_CODE0 + 8'(j))
          code_q[j] <= reg_wdata[5:0];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_out_route: assert property (term_out == exp_q)
    else $error("output terminal level differs from selected signal");
  chk_unassigned_off: assert property ((off_q & term_out) == '0)
    else $error("unassigned output terminal is on");
  chk_run_brake: assert property (clk_en && dc_brake_active &&
    code_q[0] == 6'h00 |=> !term_out[0])
    else $error("running output on during dc braking");
  chk_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  chk_stop_alarm: assert property ($rose(ctrl.forced_stop) |-> ctrl.forced_stop_alarm)
    else $error("forced stop without alarm");
  chk_stop_hold: assert property (clk_en && ctrl.forced_stop && !motor_stopped
    |=> ctrl.forced_stop)
    else $error("forced stop dropped before motor stopped");
  chk_stop_nolink: assert property (ctrl.forced_stop |-> !ctrl.link_accept)
    else $error("link commands accepted during forced stop");
  chk_fourth_stop: assert property ($rose(ctrl.use_fourth_decel) |-> ctrl.forced_stop)
    else $error("fourth ramp chosen outside forced stop");
  chk_irq_masked: assert property (clk_en && reg_wr && reg_addr == `DTFM_REG_IRQ_MASK
    && reg_wdata[1:0] == 2'b00 |=> ##1 !irq)
    else $error("interrupt high with all events masked");
  cover property ($rose(ctrl.forced_stop));
  cover property ($rose(ctrl.use_fourth_decel));
  cover property ($rose(irq));
endmodule // dtfm_mux_chk
bind dtfm_mux dtfm_mux_chk #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) dtfm_mux_chk_inst (
  .clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .term_in(term_in), .term_out(term_out),
  .freq_output_active(freq_output_active), .dc_brake_active(dc_brake_active),
  .motor_stopped(motor_stopped), .status_sig(status_sig), .ctrl(ctrl),
  .irq(irq));

// ### tb/dtfm_switch_model.sv
`timescale 1ns/1ps
module dtfm_switch_model (
  // clocking
  input wire logic        clk,
  // wanted contact positions
  input wire logic [8:0]  want,
  // pins
  output logic     [8:0]  term_in
);
  initial term_in = 9'h000;
  // contacts settle up to two cycles late, like a slow relay
  always @(posedge clk) begin
    if (want !== term_in) begin
      repeat ($urandom_range(2)) @(posedge clk);
      term_in <= want;
    end
  end
endmodule // dtfm_switch_model

// ### tb/dtfm_mux_tb.sv
`timescale 1ns/1ps
`include "dtfm_params.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module dtfm_mux_tb;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] msk;
    logic [31:0] val;
  } dtfm_note_t;
  logic clk = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic freq = 0, dc = 0, mstop = 0, e, irq;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [8:0] want = 9'h000, term_in;
  logic [4:0] term_out;
  logic [34:0] status_sig = '0;
  dtfm_pkg::dtfm_ctrl_t ctrl;
  dtfm_note_t notes[$], n;
  int failures = 0, n_compared = 0;
  always #2 clk = ~clk;
  dtfm_switch_model dtfm_switch_model_inst (.clk(clk), .want(want),
    .term_in(term_in));
  dtfm_mux dtfm_mux_inst (.clk(clk), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .term_in(term_in),
    .term_out(term_out), .freq_output_active(freq), .dc_brake_active(dc),
    .motor_stopped(mstop), .status_sig(status_sig), .ctrl(ctrl), .irq(irq));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    notes.push_back('{a, m, v & m});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // read answers come one cycle after the strobe
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d && notes.size() > 0) begin
      n = notes.pop_front();
      `CHK($sformatf("reg %0h", n.addr), n.val, reg_rdata & n.msk)
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end
  initial begin
    void'($urandom(52116));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 9; i++) rd(8'(i), 32'h3F, 32'(i));
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    $display("test reset_codes done");
    for (int c = 0; c < 36; c++) begin
      status_sig <= 35'({$urandom, $urandom}) | (35'h1 << 30);
      freq <= 1'($urandom);
      dc <= 1'($urandom);
      wr(`DTFM_REG_OUT_CODE0 + 8'(c % 5), 32'(c));
      repeat (2) @(posedge clk);
      e = (c == 30 || c > 34) ? 1'b0 : (c == 0) ? freq & ~dc : status_sig[c];
      rd(8'h30, 32'h1 << (c % 5), 32'(e) << (c % 5));
    end
    wr(`DTFM_REG_OUT_CODE0, 32'h0);
    for (int k = 0; k < 4; k++) begin
      freq <= k[0];
      dc <= k[1];
      repeat (3) @(posedge clk);
      rd(8'h30, 32'h1, 32'(k == 1));
    end
    freq <= 1'b1;
    dc <= 1'b0;
    repeat (3) @(posedge clk);
    clk_en <= 1'b0;
    freq <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("frozen run", 1'b1, term_out[0])
    clk_en <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("run after freeze", 1'b0, term_out[0])
    $display("test output_select done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, (k == 3) ? 32'd25 : (k == 0) ? 32'd24 : (k == 1) ? 32'd26 : 32'd14);
      for (int lv = 0; lv < 2; lv++) begin
        want <= 9'(lv);
        settle();
        if (k == 3) rd(8'h2C, 32'h1, 32'(lv));
        if (k == 3) rd(8'h20, 32'h3F, 32'h0);
        else rd(8'h20, 32'h80 >> k, 32'(lv) << (7 - k));
      end
    end
    wr(8'h00, 32'h0);
    freq <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      want <= 9'(s) << 4;
      settle();
      rd(8'h20, 32'h18, 32'(s) << 3);
    end
    rd(`DTFM_REG_IRQ_STAT, 32'h2, 32'h2);
    wr(`DTFM_REG_IRQ_STAT, 32'h2);
    rd(`DTFM_REG_IRQ_STAT, 32'h2, 32'h0);
    $display("test input_functions done");
    for (int f = 27; f < 29; f++) begin
      want <= 9'h003;
      freq <= 1'b0;
      settle();
      wr(8'h01, 32'(f));
      wr(8'h00, 32'd24);
      freq <= 1'b1;
      settle();
      rd(8'h20, 32'h87, 32'h80);
      wr(`DTFM_REG_IRQ_MASK, 32'h1);
      want <= 9'h001;
      settle();
      rd(8'h20, 32'h87, 32'h05 | (32'(f == 28) << 1));
      rd(`DTFM_REG_IRQ_STAT, 32'h1, 32'h1);
      `CHK("irq", 1'b1, irq)
      wr(`DTFM_REG_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk);
      `CHK("irq masked", 1'b0, irq)
      wr(`DTFM_REG_IRQ_STAT, 32'h1);
      rd(`DTFM_REG_IRQ_STAT, 32'h1, 32'h0);
      mstop <= 1'b1;
      freq <= 1'b0;
      settle();
      rd(8'h20, 32'h5, 32'h1);
      want <= 9'h003;
      freq <= 1'b0;
      settle();
      rd(8'h20, 32'h1, 32'h0);
      mstop <= 1'b0;
    end
    $display("test forced_stop done");
    repeat (3) @(posedge clk);
    print_verdict();
  end
endmodule // dtfm_mux_tb
